// File: hw/mem_window_decode.sv
// Memory window registers and forwarding decode behind an APB slave
//
// Local design decision: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "mem_window_map.svh"

//
// Contract
// - Non-prefetch base bits 15:4 writable, hold A[31:20] of lowest forwarded address
// - Non-prefetch limit bits 15:4 writable, hold A[31:20] of highest forwarded address
// - Bits 3:0 of all four registers read zero, writes ignored
// - Base compare treats A[19:0] as zero: 1-MB aligned start
// - Limit compare treats A[19:0] as FFFFFh: window ends at block top
// - Forward when address within non-prefetch base and limit, inclusive
// - Forward when address within prefetch base and limit, inclusive
// - Reset: non-prefetch base FFF0h, non-prefetch limit 0000h
// - Reset: prefetch base FFF0h, prefetch limit 0000h
module mem_window_decode #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Host memory access
  input  wire logic                  req_valid,
  input  wire logic [31:0]           req_addr,
  // Forwarding decision
  output logic                       dec_valid,
  output logic                       dec_forward,
  output logic                       dec_nonpf_hit,
  output logic                       dec_pf_hit,
  // Window fields
  output mem_window_pkg::field_t     nonprefetch_base_field,
  output mem_window_pkg::field_t     nonprefetch_limit_field,
  output mem_window_pkg::field_t     prefetch_base_field,
  output mem_window_pkg::field_t     prefetch_limit_field
);
  import mem_window_pkg::*;

  localparam logic [15:0] BASE_RST  = `BASE_RST;
  localparam logic [15:0] LIMIT_RST = `LIMIT_RST;

  // Reset image of the whole state
  localparam state_t ST_RST = '{
    win: {LIMIT_RST[`FIELD_MSB:`FIELD_LSB], BASE_RST[`FIELD_MSB:`FIELD_LSB],
          LIMIT_RST[`FIELD_MSB:`FIELD_LSB], BASE_RST[`FIELD_MSB:`FIELD_LSB]},
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h00000000,
    dec_valid: 1'b0,
    dec_forward: 1'b0,
    dec_nonpf: 1'b0,
    dec_pf: 1'b0
  };

  if (ADDR_W < 8) begin : g_chk
    $error("ADDR_W must be at least 8");
  end

  state_t      st_reg;
  state_t      st_next;
  reg_sel_t    sel;
  logic [1:0]  hit;
  logic        access;
  field_t      addr_hi;

  assign addr_hi = req_addr[`ADDR_HI:`ADDR_LO];
  assign access  = psel && penable && !st_reg.pready;

  // Address decode, word aligned, upper bits zero
  always_comb begin
    sel = SEL_NONE;
    if (paddr[1:0] == 2'b00 && paddr[ADDR_W-1:2] <= ADDR_W'(8'hFF)) begin
      unique case (paddr[7:2])
        `IDX_NP_BASE:  sel = SEL_NP_BASE;
        `IDX_NP_LIMIT: sel = SEL_NP_LIMIT;
        `IDX_PF_BASE:  sel = SEL_PF_BASE;
        `IDX_PF_LIMIT: sel = SEL_PF_LIMIT;
        default:       sel = SEL_NONE;
      endcase
    end
    if (paddr[ADDR_W-1:2] > ADDR_W'(8'hFF) >> 2) begin
      sel = SEL_NONE;
    end
  end

  // Window compare, window 0 non-prefetch, window 1 prefetch
  for (genvar w = 0; w < 2; w++) begin : g_win
    assign hit[w] = (addr_hi >= st_reg.win[2*w]) && (addr_hi <= st_reg.win[2*w+1]);
  end

  always_comb begin
    st_next = st_reg;
    st_next.pready  = 1'b0;
    st_next.pslverr = 1'b0;
    if (access) begin
      st_next.pready  = 1'b1;
      st_next.pslverr = (sel == SEL_NONE);
      st_next.prdata  = 32'h00000000;
      if (sel != SEL_NONE) begin
        if (pwrite) begin
          if (pstrb[0]) begin
            st_next.win[sel[1:0]][3:0] = pwdata[7:4];
          end
          if (pstrb[1]) begin
            st_next.win[sel[1:0]][11:4] = pwdata[15:8];
          end
        end else begin
          st_next.prdata = {16'h0000, st_reg.win[sel[1:0]], `LOW_ZERO};
        end
      end
    end
    st_next.dec_valid = req_valid;
    st_next.dec_nonpf   = req_valid && hit[0];
    st_next.dec_pf      = req_valid && hit[1];
    st_next.dec_forward = req_valid && (hit[0] || hit[1]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata                  = st_reg.prdata;
  assign pready                  = st_reg.pready;
  assign pslverr                 = st_reg.pslverr;
  assign dec_valid               = st_reg.dec_valid;
  assign dec_forward             = st_reg.dec_forward;
  assign dec_nonpf_hit           = st_reg.dec_nonpf;
  assign dec_pf_hit              = st_reg.dec_pf;
  assign nonprefetch_base_field  = st_reg.win[0];
  assign nonprefetch_limit_field = st_reg.win[1];
  assign prefetch_base_field     = st_reg.win[2];
  assign prefetch_limit_field    = st_reg.win[3];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Base write lands in the field
  a_np_base_write: assert property (
    access && pwrite && sel == SEL_NP_BASE && pstrb[1:0] == 2'b11
    |=> pready && nonprefetch_base_field == $past(pwdata[15:4]))
    else $error("non-prefetch base write lost");

  // Limit write lands in the field
  a_np_limit_write: assert property (
    access && pwrite && sel == SEL_NP_LIMIT && pstrb[1:0] == 2'b11
    |=> pready && nonprefetch_limit_field == $past(pwdata[15:4]))
    else $error("non-prefetch limit write lost");

  // Reads of mapped registers carry zero low nibble and upper half
  a_read_zero_bits: assert property (
    access && !pwrite && sel != SEL_NONE
    |=> pready && !pslverr && prdata[3:0] == 4'h0 && prdata[31:16] == 16'h0000)
    else $error("reserved bits not zero on read");

  // Lowest address of a valid non-prefetch window is inside
  a_base_edge: assert property (
    req_valid && st_reg.win[0] <= st_reg.win[1]
    && req_addr == {st_reg.win[0], `BLOCK_ZERO}
    |=> dec_nonpf_hit && dec_forward)
    else $error("base edge not forwarded");

  // Top of the prefetch limit block is inside
  a_limit_edge: assert property (
    req_valid && st_reg.win[2] <= st_reg.win[3]
    && req_addr == {st_reg.win[3], `BLOCK_ONES}
    |=> dec_pf_hit && dec_forward)
    else $error("limit top not forwarded");

  // Non-prefetch decode tied to the fields
  a_np_decode: assert property (
    req_valid |=> dec_nonpf_hit == ($past(addr_hi) >= $past(st_reg.win[0])
                                 && $past(addr_hi) <= $past(st_reg.win[1])))
    else $error("non-prefetch decode wrong");

  // Prefetch decode tied to the fields
  a_pf_decode: assert property (
    req_valid |=> dec_pf_hit == ($past(addr_hi) >= $past(st_reg.win[2])
                              && $past(addr_hi) <= $past(st_reg.win[3])))
    else $error("prefetch decode wrong");

  // Fields hold reset values right after release
  a_reset_values: assert property (
    !$past(presetn) |-> st_reg.win[0] == BASE_RST[15:4] && st_reg.win[1] == 12'h000
                    && st_reg.win[2] == BASE_RST[15:4] && st_reg.win[3] == 12'h000)
    else $error("reset values wrong");

  a_empty_window: assert property (
    req_valid && st_reg.win[0] > st_reg.win[1] && st_reg.win[2] > st_reg.win[3]
    |=> !dec_forward && !dec_nonpf_hit && !dec_pf_hit)
    else $error("inverted window forwarded");

  a_apb_answer: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer not one cycle");

  // Prefetch base write lands in the field
  a_pf_base_write: assert property (
    access && pwrite && sel == SEL_PF_BASE && pstrb[1:0] == 2'b11
    |=> pready && prefetch_base_field == $past(pwdata[15:4]))
    else $error("prefetch base write lost");

  // Prefetch limit write lands in the field
  a_pf_limit_write: assert property (
    access && pwrite && sel == SEL_PF_LIMIT && pstrb[1:0] == 2'b11
    |=> pready && prefetch_limit_field == $past(pwdata[15:4]))
    else $error("prefetch limit write lost");

  // Unmapped access refused, reads zero, writes nothing
  a_unmapped_error: assert property (
    access && sel == SEL_NONE
    |=> pready && pslverr && prdata == 32'h00000000 && $stable(st_reg.win))
    else $error("unmapped access not refused");

  // Fields change only on a bus access
  a_field_hold: assert property (
    !access
    |=> $stable(st_reg.win))
    else $error("field changed without access");

  // Every access phase answered next cycle
  a_access_acked: assert property (
    access
    |=> pready)
    else $error("access not answered");

  a_ready_pulse: assert property (
    pready
    |=> !pready)
    else $error("ready held too long");

  // Every host access gets a decision
  a_valid_follows: assert property (
    req_valid
    |=> dec_valid)
    else $error("decision missing");

  a_idle_quiet: assert property (
    !req_valid
    |=> !dec_valid && !dec_forward && !dec_nonpf_hit && !dec_pf_hit)
    else $error("decision without access");

  // Forward is the union of both window hits
  a_fwd_union: assert property (
    dec_forward == (dec_nonpf_hit || dec_pf_hit)
    )
    else $error("forward not union of hits");

  // Lowest address of the prefetch window is inside
  a_pf_base_edge: assert property (
    req_valid && st_reg.win[2] <= st_reg.win[3]
    && req_addr == {st_reg.win[2], `BLOCK_ZERO}
    |=> dec_pf_hit && dec_forward)
    else $error("prefetch base edge not forwarded");

  // Top of the non-prefetch limit block is inside
  a_np_limit_edge: assert property (
    req_valid && st_reg.win[0] <= st_reg.win[1]
    && req_addr == {st_reg.win[1], `BLOCK_ONES}
    |=> dec_nonpf_hit && dec_forward)
    else $error("non-prefetch limit top not forwarded");

  a_np_empty: assert property (
    req_valid && st_reg.win[0] > st_reg.win[1]
    |=> !dec_nonpf_hit)
    else $error("inverted non-prefetch window hit");

  a_pf_empty: assert property (
    req_valid && st_reg.win[2] > st_reg.win[3]
    |=> !dec_pf_hit)
    else $error("inverted prefetch window hit");

  c_pf_write: cover property (access && pwrite && sel == SEL_PF_LIMIT);
  c_np_write: cover property (access && pwrite && sel == SEL_NP_BASE);
  c_np_hit:   cover property (dec_nonpf_hit && !dec_pf_hit);
  c_pf_hit:   cover property (dec_pf_hit);
  c_unmapped: cover property (pready && pslverr);

endmodule
`default_nettype wire

// File: hw/mem_window_map.svh
// Offsets, field positions and reset values of the memory window registers
`ifndef MEM_WINDOW_MAP_SVH
`define MEM_WINDOW_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_NP_BASE   6'h20
`define IDX_NP_LIMIT  6'h22
`define IDX_PF_BASE   6'h24
`define IDX_PF_LIMIT  6'h26

// Writable field within each 16-bit window register
`define FIELD_MSB     15
`define FIELD_LSB     4
`define FIELD_W       12
`define LOW_ZERO      4'h0

// Reset values
`define BASE_RST      16'hFFF0
`define LIMIT_RST     16'h0000

// Address bits compared against the fields
`define ADDR_HI       31
`define ADDR_LO       20
`define BLOCK_ZERO    20'h00000
`define BLOCK_ONES    20'hFFFFF

`endif

// File: hw/mem_window_pkg.sv
// Types shared by the memory window decoder
`include "mem_window_map.svh"

package mem_window_pkg;

  typedef logic [`FIELD_W-1:0] field_t;

  typedef enum logic [2:0] {
    SEL_NP_BASE  = 3'b000,
    SEL_NP_LIMIT = 3'b001,
    SEL_PF_BASE  = 3'b010,
    SEL_PF_LIMIT = 3'b011,
    SEL_NONE     = 3'b100
  } reg_sel_t;

  typedef struct packed {
    field_t [3:0] win;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
    logic         dec_valid;
    logic         dec_forward;
    logic         dec_nonpf;
    logic         dec_pf;
  } state_t;

endpackage

// File: tb/fwd_sink.sv
// Far-side model counting accesses forwarded to the secondary link
`timescale 1ns/1ns
`default_nettype none
module fwd_sink (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Forwarding decision
  input  wire logic       dec_valid,
  input  wire logic       dec_forward,
  // Accepted access count
  output logic [7:0]      n_fwd
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_fwd <= 8'h00;
    end else if (dec_valid && dec_forward) begin
      n_fwd <= n_fwd + 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Testbench for the memory window decoder
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, req_valid = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, req_addr = 32'h0, prdata;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, dec_valid, dec_forward, dec_nonpf_hit, dec_pf_hit;
  logic [7:0]  n_fwd;
  logic [31:0] r;
  logic        er;
  int          n_mismatch = 0, checked = 0, cyc = 0;
  // Address and expected {valid, forward, nonpf, pf}
  localparam logic [31:0] ADR [8] = '{32'h122FFFFF, 32'h12300000, 32'h124FFFFF, 32'h12500000,
                                       32'h7FFFFFFF, 32'h80000000, 32'h80FFFFFF, 32'h81000000};
  localparam logic [3:0]  EXP [8] = '{4'h8, 4'hE, 4'hE, 4'h8, 4'h8, 4'hD, 4'hD, 4'h8};

  always #4 pclk = ~pclk;

  mem_window_decode i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_valid(req_valid), .req_addr(req_addr), .dec_valid(dec_valid),
    .dec_forward(dec_forward), .dec_nonpf_hit(dec_nonpf_hit), .dec_pf_hit(dec_pf_hit),
    .nonprefetch_base_field(), .nonprefetch_limit_field(), .prefetch_base_field(),
    .prefetch_limit_field()
  );

  fwd_sink i_sink (
    .pclk(pclk), .presetn(presetn), .dec_valid(dec_valid), .dec_forward(dec_forward), .n_fwd(n_fwd)
  );

  task complete_run;
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask

  // One host access, decision seen one cycle later
  task dec(input logic [31:0] a, input logic [3:0] e);
    req_valid <= 1'b1;
    req_addr <= a;
    @(posedge pclk);
    req_valid <= 1'b0;
    @(posedge pclk);
    chk({28'h0, dec_valid, dec_forward, dec_nonpf_hit, dec_pf_hit}, {28'h0, e});
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      complete_run;
    end
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h080, 32'h0000FFF0);
    rd(12'h088, 32'h00000000);
    rd(12'h090, 32'h0000FFF0);
    rd(12'h098, 32'h00000000);
    dec(32'h00000000, 4'h8);
    dec(32'hFFF00000, 4'h8);
    // Registers programmed before forwarding is relied on, graphics memory prefetchable
    apb(1'b1, 12'h080, 32'hFFFF1235);
    apb(1'b1, 12'h088, 32'hFFFF124F);
    apb(1'b1, 12'h090, 32'h00008005);
    apb(1'b1, 12'h098, 32'h000080FF);
    rd(12'h080, 32'h00001230);
    rd(12'h088, 32'h00001240);
    rd(12'h090, 32'h00008000);
    rd(12'h098, 32'h000080F0);
    for (int i = 0; i < 8; i++) begin
      dec(ADR[i], EXP[i]);
    end
    apb(1'b1, 12'h100, 32'h0000FFF0);
    chk({31'h0, er}, 32'h1);
    rd(12'h080, 32'h00001230);
    apb(1'b1, 12'h080, 32'h00001250);
    dec(32'h12400000, 4'h8);
    dec(32'h80000000, 4'hD);
    @(posedge pclk);
    chk({24'h0, n_fwd}, 32'h5);
    complete_run;
  end
endmodule
`default_nettype wire
